// ===== rtl/bca_core.sv
// Battery charge accounting core: counters, empty flags, configuration decode
`timescale 1ns/1ps

// Behaviour
// - Supply return: on corruption clear counter, reload capacity
// - Empty thresholds 1.00 V and 0.90 V
// - Empty flags latch until next valid charge
// - Delay from capacity band and temperature
// - Overload flag suspends empty monitoring
// - Zero to 1eh then 05h reinitialises
// - Temperature code upper digit, ten-degree steps
// - Discharge load compensated by 0eh value
// - Counter offset corrected by 0bh value
// - Transfer never drops capacity over a quarter
// - First two inputs select full count, scale
// - Third input selects self-discharge rate
// - Fourth input selects display and overload
// - Fifth input selects charge efficiency
// - Sixth input selects offset adjustment
// - Counter bounded between zero and capacity
// - Counter cleared on init, first charge
// - Charge complete loads counter with capacity
// - Self-discharge counts only while counter nonzero
// - Discharge count clears at full, saturates
// - Capacity learned only when four conditions hold
// - Valid charge needs over two updates
// - Charge complete sets valid discharge flag
module bca_core
  import bca_pkg::*;
#(
  parameter int SEC_CYCLES = CLK_HZ
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Program pins, two bits each: 0 low, 1 floating, 2 high
  input wire logic [11:0] three_level_config_input,
  // Measurement front end
  input wire logic [11:0] battery_sense_voltage,
  input wire logic signed [7:0] temperature_c,
  input wire logic backup_supply_input,
  input wire logic charge_pulse,
  input wire logic charge_active,
  input wire logic fast_charge,
  input wire logic discharge_pulse,
  input wire logic self_discharge_pulse,
  input wire logic overload_detect,
  input wire logic charge_complete,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Accounting state
  output logic [15:0] available_charge_counter,
  output logic [15:0] learned_capacity,
  output logic [15:0] discharge_count,
  output logic [7:0] second_flags_register,
  output logic [7:0] temperature_code,
  // Decoded configuration
  output logic [15:0] full_count,
  output logic [11:0] count_scale_div,
  output logic [4:0] self_discharge_x10,
  output logic relative_mode,
  output logic [6:0] overload_level,
  output logic [6:0] charge_efficiency_pct,
  output logic signed [8:0] discharge_offset_uv
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] temp_to_code(input logic signed [7:0] t);
    logic signed [9:0] s;
    s = 10'(t) + 10'sd40;
    if (t < -8'sd30)
      temp_to_code = 4'h0;
    else if (s >= 10'sd130)
      temp_to_code = TEMP_MAX_CODE;
    else
      temp_to_code = 4'(s / 10'sd10);
  endfunction : temp_to_code

  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [1:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {15'h0, b};
    sat_add = s[16] ? COUNT_MAX : s[15:0];
  endfunction : sat_add

  // ****************************************
  // Configuration sampling
  // ****************************************
  logic init_req;
  logic do_init;
  logic [11:0] three_level_config_input_q;
  bca_seq_t seq_state;
  logic serial_reset;
  logic [7:0] offset_correction;
  logic [7:0] load_compensation;
  logic [15:0] full_three_level_config_input;
  logic [3:0] tcode;
  logic [15:0] dec_full;
  logic [11:0] dec_scale;
  logic [3:0] pin_sel;

  assign do_init = init_req;
  // Pins feed the decode during init, so capacity loads from the live pins, else the stored sample
  assign pin_sel = do_init ? three_level_config_input[3:0] : three_level_config_input_q[3:0];
  assign tcode = temp_to_code(temperature_c);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      init_req <= 1'b1;
    else
      init_req <= serial_reset;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      three_level_config_input_q <= 12'h000;
    else if (do_init)
      three_level_config_input_q <= three_level_config_input;
  end

  always_comb
  begin
    case (pin_sel)
      {LVL_H, LVL_H}: begin dec_full = 16'd27136; dec_scale = 12'd320; end
      {LVL_Z, LVL_H}: begin dec_full = 16'd24064; dec_scale = 12'd320; end
      {LVL_L, LVL_H}: begin dec_full = 16'd41472; dec_scale = 12'd640; end
      {LVL_H, LVL_Z}: begin dec_full = 16'd35072; dec_scale = 12'd640; end
      {LVL_Z, LVL_Z}: begin dec_full = 16'd28672; dec_scale = 12'd640; end
      {LVL_L, LVL_Z}: begin dec_full = 16'd44800; dec_scale = 12'd1280; end
      {LVL_H, LVL_L}: begin dec_full = 16'd30720; dec_scale = 12'd1280; end
      {LVL_Z, LVL_L}: begin dec_full = 16'd38400; dec_scale = 12'd2560; end
      default: begin dec_full = 16'd12800; dec_scale = 12'd2560; end
    endcase
  end

  // Decode tables registered so every config output is a flop
  logic [1:0] tband;
  logic [6:0] next_eff;
  assign tband = (tcode <= 4'h6) ? 2'd0 : (tcode <= 4'h8) ? 2'd1 : 2'd2;

  always_comb
  begin
    case (three_level_config_input_q[9:8])
      LVL_Z: next_eff = EFF_FULL_PCT;
      LVL_H: next_eff = fast_charge ? 7'(95 - 5 * tband) : 7'(80 - 5 * tband);
      default: next_eff = fast_charge ? 7'(95 - 5 * tband) : 7'(85 - 5 * tband);
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      full_count <= 16'h0000;
      count_scale_div <= 12'h000;
      self_discharge_x10 <= 5'h00;
      relative_mode <= 1'b1;
      overload_level <= OVL_HIGH_MV;
      charge_efficiency_pct <= EFF_FULL_PCT;
      discharge_offset_uv <= OFS_L_UV;
      temperature_code <= 8'h00;
    end
    else
    begin
      full_count <= dec_full;
      count_scale_div <= dec_scale;
      self_discharge_x10 <= (three_level_config_input_q[5:4] == LVL_H) ? SDR_H_X10 :
                            (three_level_config_input_q[5:4] == LVL_Z) ? SDR_Z_X10 : SDR_L_X10;
      relative_mode <= (three_level_config_input_q[7:6] != LVL_L);
      overload_level <= (three_level_config_input_q[7:6] != LVL_L) ? OVL_HIGH_MV : OVL_LOW_MV;
      charge_efficiency_pct <= next_eff;
      discharge_offset_uv <= (three_level_config_input_q[11:10] == LVL_H) ? OFS_H_UV :
                             (three_level_config_input_q[11:10] == LVL_Z) ? OFS_Z_UV : OFS_L_UV;
      temperature_code <= {tcode, 4'h0};
    end
  end

  // ****************************************
  // Register writes and serial reset sequence
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      seq_state <= SEQ_IDLE;
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_FULL_THREE_LEVEL_CONFIG_INPUT && reg_wdata == SERIAL_RESET_DATA)
        seq_state <= SEQ_ARMED;
      else
        seq_state <= SEQ_IDLE;
    end
  end

  assign serial_reset = reg_wr && seq_state == SEQ_ARMED && reg_addr == ADDR_LEARNED
                        && reg_wdata == SERIAL_RESET_DATA;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      offset_correction <= 8'h00;
      load_compensation <= 8'h00;
    end
    else if (reg_wr && reg_addr == ADDR_OFFSET)
      offset_correction <= reg_wdata;
    else if (reg_wr && reg_addr == ADDR_LOAD_COMPENSATION)
      load_compensation <= reg_wdata;
  end

  // ****************************************
  // Count compensation
  // ****************************************
  logic [7:0] eff_acc;
  logic [7:0] ofs_acc;
  logic [7:0] lc_acc;
  logic [8:0] eff_sum;
  logic [8:0] ofs_sum;
  logic [8:0] lc_sum;
  logic inc_raw;
  logic ofs_carry;
  logic lc_carry;
  logic [1:0] inc_cnt;
  logic [1:0] dec_cnt;

  assign eff_sum = {1'b0, eff_acc} + {2'b00, charge_efficiency_pct};
  assign inc_raw = charge_pulse && eff_sum >= {2'b00, EFF_FULL_PCT};
  assign ofs_sum = {1'b0, ofs_acc} + {1'b0, offset_correction};
  assign ofs_carry = inc_raw && ofs_sum[8];
  assign lc_sum = {1'b0, lc_acc} + {1'b0, load_compensation};
  assign lc_carry = discharge_pulse && lc_sum[8];

  // Offset error eats the occasional charge count
  assign inc_cnt = (inc_raw && !ofs_carry) ? 2'd1 : 2'd0;
  // Load compensation adds an extra count now and then
  assign dec_cnt = 2'(discharge_pulse) + 2'(lc_carry);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      eff_acc <= 8'h00;
      ofs_acc <= 8'h00;
      lc_acc <= 8'h00;
    end
    else
    begin
      if (charge_pulse)
        eff_acc <= inc_raw ? 8'(eff_sum - {2'b00, EFF_FULL_PCT}) : eff_sum[7:0];
      if (inc_raw)
        ofs_acc <= ofs_sum[7:0];
      if (discharge_pulse)
        lc_acc <= lc_sum[7:0];
    end
  end

  // ****************************************
  // Valid charge and supply recovery
  // ****************************************
  logic [1:0] charge_updates;
  logic valid_charge;
  logic supply_q;
  logic [15:0] check_q;
  logic [15:0] check_now;
  logic corrupt;

  assign valid_charge = charge_active && inc_cnt != 2'd0 && charge_updates == VALID_CHARGE_UPDATES;

  always_ff @(posedge ref_clk)
  begin
    if (srst || !charge_active)
      charge_updates <= 2'd0;
    else if (inc_cnt != 2'd0 && charge_updates != 2'd3)
      charge_updates <= charge_updates + 2'd1;
  end

  assign check_now = learned_capacity ^ full_three_level_config_input ^ {offset_correction, load_compensation};
  assign corrupt = backup_supply_input && !supply_q && check_now != check_q;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      supply_q <= 1'b0;
      check_q <= 16'h0000;
    end
    else
    begin
      supply_q <= backup_supply_input;
      if (backup_supply_input && supply_q)
        check_q <= check_now;
    end
  end

  // ****************************************
  // Empty-voltage detection
  // ****************************************
  logic [31:0] delay_cycles;
  logic [31:0] first_cnt;
  logic [31:0] final_cnt;
  logic [2:0] delay_s;
  logic below_first;
  logic below_final;
  logic [18:0] nac5;
  logic [18:0] lmd2;

  assign nac5 = 19'(available_charge_counter) * 19'd5;
  assign lmd2 = 19'(learned_capacity) * 19'd2;
  assign below_first = battery_sense_voltage < FIRST_EMPTY_MV;
  assign below_final = battery_sense_voltage < (FIRST_EMPTY_MV - FINAL_EMPTY_DROP_MV);

  always_comb
  begin
    if (nac5 > lmd2)
      delay_s = (tcode <= 4'h4) ? 3'd7 : (tcode <= 4'h6) ? 3'd6 : 3'd5;
    else if (nac5 >= 19'(learned_capacity))
      delay_s = (tcode <= 4'h4) ? 3'd4 : (tcode <= 4'h6) ? 3'd3 : 3'd2;
    else
      delay_s = 3'd2;
  end
  assign delay_cycles = 32'(delay_s) * 32'(SEC_CYCLES);

  always_ff @(posedge ref_clk)
  begin
    if (srst || overload_detect || !below_first)
      first_cnt <= 32'h0;
    else if (first_cnt < delay_cycles)
      first_cnt <= first_cnt + 32'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || overload_detect || !below_final)
      final_cnt <= 32'h0;
    else if (final_cnt < delay_cycles)
      final_cnt <= final_cnt + 32'h1;
  end

  // ****************************************
  // Flags
  // ****************************************
  logic first_empty;
  logic final_empty;
  logic valid_discharge;
  logic overload_flag;
  logic temp_ok_at_empty;
  logic no_charge_since_full;
  logic learn_event;
  logic learn_ok;
  logic [15:0] self_count;
  logic [15:0] learn_floor;
  logic [22:0] self_x100;
  logic [22:0] nac_x6;

  assign learn_event = valid_charge && first_empty;
  assign self_x100 = 23'(self_count) * 23'd100;
  assign nac_x6 = 23'(available_charge_counter) * 23'(SELF_LIMIT_PCT);
  assign learn_ok = no_charge_since_full && self_x100 < nac_x6 && temp_ok_at_empty && valid_discharge;
  assign learn_floor = learned_capacity - learned_capacity / 16'(TRANSFER_MAX_DROP_DIV);

  always_ff @(posedge ref_clk)
  begin
    if (srst || do_init || corrupt)
    begin
      first_empty <= 1'b0;
      final_empty <= 1'b0;
      temp_ok_at_empty <= 1'b0;
    end
    else
    begin
      if (!first_empty && first_cnt == delay_cycles && below_first)
      begin
        first_empty <= 1'b1;
        temp_ok_at_empty <= tcode >= TEMP_ZERO_C_CODE;
      end
      else if (valid_charge)
        first_empty <= 1'b0;
      if (!final_empty && final_cnt == delay_cycles && below_final)
        final_empty <= 1'b1;
      else if (valid_charge)
        final_empty <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || do_init)
      valid_discharge <= 1'b0;
    else if (charge_complete)
      valid_discharge <= 1'b1;
    else if (learn_event)
      valid_discharge <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      overload_flag <= 1'b0;
    else
      overload_flag <= overload_detect;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || do_init)
      no_charge_since_full <= 1'b0;
    else if (available_charge_counter == learned_capacity)
      no_charge_since_full <= 1'b1;
    else if (valid_charge)
      no_charge_since_full <= 1'b0;
  end

  // ****************************************
  // Counters
  // ****************************************
  logic [16:0] nac_up;
  logic [15:0] nac_dec;

  assign nac_up = {1'b0, available_charge_counter} + {15'h0, inc_cnt};
  assign nac_dec = 16'(dec_cnt) + 16'(self_discharge_pulse);

  always_ff @(posedge ref_clk)
  begin
    if (srst || do_init)
      full_three_level_config_input <= dec_full;
    else if (reg_wr && reg_addr == ADDR_FULL_THREE_LEVEL_CONFIG_INPUT)
      full_three_level_config_input <= {reg_wdata, 8'h00};
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || do_init)
      learned_capacity <= dec_full;
    else if (corrupt)
      learned_capacity <= full_three_level_config_input;
    else if (learn_event && learn_ok)
      learned_capacity <= (discharge_count < learn_floor) ? learn_floor : discharge_count;
    else if (reg_wr && reg_addr == ADDR_LEARNED)
      learned_capacity <= {reg_wdata, 8'h00};
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || do_init || corrupt || learn_event)
      available_charge_counter <= 16'h0000;
    else if (charge_complete)
      available_charge_counter <= learned_capacity;
    else if (nac_dec != 16'h0000)
      available_charge_counter <= (available_charge_counter > nac_dec) ?
                                  available_charge_counter - nac_dec : 16'h0000;
    else if (nac_up > {1'b0, learned_capacity})
      available_charge_counter <= learned_capacity;
    else
      available_charge_counter <= nac_up[15:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || do_init || available_charge_counter == learned_capacity)
      discharge_count <= 16'h0000;
    else if (self_discharge_pulse && available_charge_counter != 16'h0000)
      discharge_count <= sat_add(discharge_count, dec_cnt + 2'd1);
    else
      discharge_count <= sat_add(discharge_count, dec_cnt);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || do_init || available_charge_counter == learned_capacity)
      self_count <= 16'h0000;
    else if (self_discharge_pulse && available_charge_counter != 16'h0000)
      self_count <= sat_add(self_count, 2'd1);
  end

  // ****************************************
  // Read port
  // ****************************************
  assign second_flags_register = {4'h0, valid_discharge, final_empty, first_empty, overload_flag};

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_NAC_LO: reg_rdata <= available_charge_counter[7:0];
        ADDR_NAC_HI: reg_rdata <= available_charge_counter[15:8];
        ADDR_DCR_HI: reg_rdata <= discharge_count[15:8];
        ADDR_LEARNED: reg_rdata <= learned_capacity[15:8];
        ADDR_TEMP: reg_rdata <= temperature_code;
        ADDR_FLAGS2: reg_rdata <= second_flags_register;
        ADDR_OFFSET: reg_rdata <= offset_correction;
        ADDR_LOAD_COMPENSATION: reg_rdata <= load_compensation;
        ADDR_FULL_THREE_LEVEL_CONFIG_INPUT: reg_rdata <= full_three_level_config_input[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  nac_bound_a: assert property (@(posedge ref_clk) disable iff (srst)
    available_charge_counter <= learned_capacity || $past(reg_wr)) else $error("counter above capacity");
  done_load_a: assert property (@(posedge ref_clk) disable iff (srst)
    charge_complete && !do_init && !corrupt && !learn_event |=> available_charge_counter == $past(learned_capacity)
    && valid_discharge) else $error("charge complete not applied");
  dcr_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    available_charge_counter == learned_capacity |=> discharge_count == 16'h0000) else $error("dcr not cleared");
  dcr_sat_a: assert property (@(posedge ref_clk) disable iff (srst)
    discharge_count == COUNT_MAX && available_charge_counter != learned_capacity && !do_init
    |=> discharge_count == COUNT_MAX) else $error("dcr wrapped");
  empty_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    first_empty && !valid_charge && !do_init && !corrupt |=> first_empty) else $error("flag lost");
  ovl_block_a: assert property (@(posedge ref_clk) disable iff (srst)
    overload_detect |=> first_cnt == 32'h0 && final_cnt == 32'h0) else $error("monitor not suspended");
  serial_init_a: assert property (@(posedge ref_clk) disable iff (srst)
    serial_reset |=> do_init ##1 available_charge_counter == 16'h0000) else $error("serial reset ignored");
  learn_floor_a: assert property (@(posedge ref_clk) disable iff (srst)
    learn_event && learn_ok && !do_init && !corrupt |=> learned_capacity >= $past(learn_floor))
    else $error("capacity dropped too far");
  temp_code_a: assert property (@(posedge ref_clk) disable iff (srst)
    temperature_c < -8'sd30 |=> temperature_code == 8'h00) else $error("cold code wrong");

endmodule : bca_core

// ===== rtl/bca_pkg.sv
// Constants and types for the battery charge accounting core
package bca_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] ADDR_NAC_LO = 5'h02;
  localparam logic [4:0] ADDR_NAC_HI = 5'h03;
  localparam logic [4:0] ADDR_DCR_HI = 5'h04;
  localparam logic [4:0] ADDR_LEARNED = 5'h05;
  localparam logic [4:0] ADDR_TEMP = 5'h06;
  localparam logic [4:0] ADDR_FLAGS2 = 5'h07;
  localparam logic [4:0] ADDR_OFFSET = 5'h0B;
  localparam logic [4:0] ADDR_LOAD_COMPENSATION = 5'h0E;
  localparam logic [4:0] ADDR_FULL_THREE_LEVEL_CONFIG_INPUT = 5'h1E;
  localparam logic [7:0] SERIAL_RESET_DATA = 8'h00;

  // Second flags register bit positions
  localparam int FLG_OVERLOAD = 0;
  localparam int FLG_FIRST_EMPTY = 1;
  localparam int FLG_FINAL_EMPTY = 2;
  localparam int FLG_VALID_DISCH = 3;

  // ****************************************
  // Thresholds and timing
  // ****************************************
  localparam logic [11:0] FIRST_EMPTY_MV = 12'd1000;
  localparam logic [11:0] FINAL_EMPTY_DROP_MV = 12'd100;
  localparam int CLK_HZ = 20000000;
  localparam logic [1:0] VALID_CHARGE_UPDATES = 2'd2;
  localparam logic [7:0] TRANSFER_MAX_DROP_DIV = 8'd4;
  localparam logic [7:0] SELF_LIMIT_PCT = 8'd6;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [2:0] POST_RELEASE_S = 3'd4;

  // ****************************************
  // Three-level input encoding and tables
  // ****************************************
  localparam logic [1:0] LVL_L = 2'h0;
  localparam logic [1:0] LVL_Z = 2'h1;
  localparam logic [1:0] LVL_H = 2'h2;
  localparam logic [3:0] TEMP_ZERO_C_CODE = 4'h4;
  localparam logic [3:0] TEMP_MAX_CODE = 4'hC;
  localparam logic [6:0] OVL_HIGH_MV = 7'd75;
  localparam logic [6:0] OVL_LOW_MV = 7'd25;
  localparam logic [4:0] SDR_H_X10 = 5'd16;
  localparam logic [4:0] SDR_Z_X10 = 5'd8;
  localparam logic [4:0] SDR_L_X10 = 5'd2;
  localparam logic signed [8:0] OFS_H_UV = -9'sd150;
  localparam logic signed [8:0] OFS_Z_UV = -9'sd75;
  localparam logic signed [8:0] OFS_L_UV = 9'sd0;
  localparam logic [6:0] EFF_FULL_PCT = 7'd100;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_ARMED = 1'b1
  } bca_seq_t;

endpackage : bca_pkg

// ===== verification/battery_charge_accounting_tb.sv
// Self-checking bench for the charge accounting core
`timescale 1ns/1ps
module battery_charge_accounting_tb
  import bca_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] cfg = 12'h491;
  logic [11:0] vsense = 12'd1200;
  logic signed [7:0] temp_c = 8'sd25;
  logic chg_p = 1'b0, chg_a = 1'b0, fast = 1'b0, dis_p = 1'b0, self_p = 1'b0;
  logic ovl = 1'b0, done_in = 1'b0, bkp = 1'b1;
  logic [4:0] ra;
  logic [7:0] wd, rdat, rv;
  logic wr, rd;
  logic [15:0] acc, cap, dcnt, fc;
  logic [7:0] flg, tcode;
  logic [11:0] scl;
  logic [4:0] sdr;
  logic rel;
  logic [6:0] ovlv, eff;
  logic signed [8:0] ofs;
  int mismatches = 0;
  int checks = 0;

  always #25 ref_clk = ~ref_clk;

  bca_core #(.SEC_CYCLES(10)) dut (.ref_clk(ref_clk), .srst(srst), .three_level_config_input(cfg),
    .battery_sense_voltage(vsense), .temperature_c(temp_c), .backup_supply_input(bkp), .charge_pulse(chg_p),
    .charge_active(chg_a), .fast_charge(fast), .discharge_pulse(dis_p), .self_discharge_pulse(self_p),
    .overload_detect(ovl), .charge_complete(done_in), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .available_charge_counter(acc), .learned_capacity(cap),
    .discharge_count(dcnt), .second_flags_register(flg), .temperature_code(tcode), .full_count(fc),
    .count_scale_div(scl), .self_discharge_x10(sdr), .relative_mode(rel), .overload_level(ovlv),
    .charge_efficiency_pct(eff), .discharge_offset_uv(ofs));

  bca_host host (.ref_clk(ref_clk), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done();
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_config();
    chk("full_count", 16'hAF00, fc);
    chk("learned", 16'hAF00, cap);
    chk("efficiency", 16'h0055, {9'h000, eff});
    chk("scale", 16'h0500, {4'h0, scl});
    chk("self_rate", 16'h0008, {11'h000, sdr});
    chk("relative", 16'h0001, {15'h0000, rel});
    chk("ovl_level", 16'h004B, {9'h000, ovlv});
    chk("offset_adj", 16'hFFB5, {{7{ofs[8]}}, ofs});
    chk("counter", 16'h0000, acc);
  endtask : t_config

  task automatic t_full_then_discharge();
    host.write(ADDR_LOAD_COMPENSATION, 8'h00);
    host.write(ADDR_OFFSET, 8'h00);
    @(negedge ref_clk);
    done_in = 1'b1;
    @(negedge ref_clk);
    done_in = 1'b0;
    chk("counter", 16'hAF00, acc);
    chk("valid_dis", 16'h0001, {15'h0000, flg[FLG_VALID_DISCH]});
    chk("dcount", 16'h0000, dcnt);
    repeat (3)
    begin
      dis_p = 1'b1;
      @(negedge ref_clk);
      dis_p = 1'b0;
      @(negedge ref_clk);
    end
    chk("counter", 16'hAEFD, acc);
    // First count lands while still full, so the clear wins
    chk("dcount", 16'h0002, dcnt);
  endtask : t_full_then_discharge

  task automatic t_empty();
    // Mid band, capacity above 40 percent: 6 s of 10 cycles plus one
    vsense = 12'd950;
    repeat (55) @(negedge ref_clk);
    chk("first_empty", 16'h0000, {15'h0000, flg[FLG_FIRST_EMPTY]});
    repeat (15) @(negedge ref_clk);
    chk("first_empty", 16'h0001, {15'h0000, flg[FLG_FIRST_EMPTY]});
    chk("final_empty", 16'h0000, {15'h0000, flg[FLG_FINAL_EMPTY]});
    vsense = 12'd1200;
    repeat (5) @(negedge ref_clk);
    chk("first_empty", 16'h0001, {15'h0000, flg[FLG_FIRST_EMPTY]});
    ovl = 1'b1;
    vsense = 12'd850;
    repeat (80) @(negedge ref_clk);
    chk("final_empty", 16'h0000, {15'h0000, flg[FLG_FINAL_EMPTY]});
    host.read(ADDR_FLAGS2, rv);
    chk("flags_read", 16'h0001, {15'h0000, rv[FLG_OVERLOAD]});
    ovl = 1'b0;
    vsense = 12'd1200;
  endtask : t_empty

  task automatic t_learn();
    // Efficiency 85: counted increments on pulses 2, 3 and 4
    chg_a = 1'b1;
    repeat (4)
    begin
      chg_p = 1'b1;
      @(negedge ref_clk);
      chg_p = 1'b0;
      @(negedge ref_clk);
    end
    chg_a = 1'b0;
    chk("learned", 16'h8340, cap);
    chk("counter", 16'h0000, acc);
    chk("first_empty", 16'h0000, {15'h0000, flg[FLG_FIRST_EMPTY]});
  endtask : t_learn

  task automatic t_serial_reset();
    @(negedge ref_clk);
    done_in = 1'b1;
    @(negedge ref_clk);
    done_in = 1'b0;
    host.write(ADDR_FULL_THREE_LEVEL_CONFIG_INPUT, SERIAL_RESET_DATA);
    host.write(ADDR_LEARNED, SERIAL_RESET_DATA);
    repeat (3) @(negedge ref_clk);
    chk("counter", 16'h0000, acc);
    chk("learned", 16'hAF00, cap);
    chk("first_empty", 16'h0000, {15'h0000, flg[FLG_FIRST_EMPTY]});
  endtask : t_serial_reset

  task automatic t_supply();
    @(negedge ref_clk);
    done_in = 1'b1;
    @(negedge ref_clk);
    done_in = 1'b0;
    // Capacity disturbed while the supply is down
    bkp = 1'b0;
    host.write(ADDR_LEARNED, 8'h90);
    bkp = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("counter", 16'h0000, acc);
    chk("learned", 16'hAF00, cap);
  endtask : t_supply

  task automatic t_temperature();
    logic signed [7:0] tv [4] = '{-8'sd35, 8'sd5, 8'sd25, 8'sd90};
    logic [7:0] te [4] = '{8'h00, 8'h40, 8'h60, 8'hC0};
    for (int i = 0; i < 4; i++)
    begin
      temp_c = tv[i];
      repeat (3) @(negedge ref_clk);
      chk("temp_code", {8'h00, te[i]}, {8'h00, tcode});
    end
  endtask : t_temperature

  initial
  begin
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    t_config();
    t_full_then_discharge();
    t_empty();
    t_learn();
    t_serial_reset();
    t_supply();
    t_temperature();
    test_done();
  end

  initial
  begin
    #(50 * 2000);
    mismatches++;
    test_done();
  end
endmodule : battery_charge_accounting_tb

// ===== verification/bca_host.sv
// Host processor model driving the register port
`timescale 1ns/1ps
module bca_host
  import bca_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic write(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // Released data bus shows the inverted last value, not the last value
    reg_wdata = ~d;
  endtask : write

  task automatic read(input logic [4:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : read
endmodule : bca_host
